// >>> logic/sync_cfg_pkg.sv
package sync_cfg_pkg;

    // =========================================================
    // Register bus geometry
    localparam int ADDR_W = 7;
    localparam int DATA_W = 16;

    // =========================================================
    // Register offsets
    localparam logic [6:0] OFS_EXT_INPUT_PIN_CONFIG     = 7'h3a;
    localparam logic [6:0] OFS_LOCK_INDICATOR_SELECT    = 7'h3b;
    localparam logic [6:0] OFS_LOCK_INDICATOR_DELAY_REG = 7'h3c;
    localparam logic [6:0] OFS_MODULATOR_RESET_WAIT_HIGH = 7'h45;
    localparam logic [6:0] OFS_MODULATOR_RESET_WAIT_LOW = 7'h46;
    localparam logic [6:0] OFS_FRAME_REF_CONTROL        = 7'h47;
    localparam logic [6:0] OFS_FRAME_REF_DIVIDER_REG    = 7'h48;
    localparam logic [6:0] OFS_FRAME_REF_DELAY_A        = 7'h49;
    localparam logic [6:0] OFS_FRAME_REF_DELAY_B        = 7'h4a;
    localparam logic [6:0] OFS_BLOCK_STATUS             = 7'h7f;

    // =========================================================
    // Reset values
    localparam logic [15:0] RST_EXT_INPUT_PIN_CONFIG     = 16'h8001;
    localparam logic [15:0] RST_LOCK_INDICATOR_SELECT    = 16'h0001;
    localparam logic [15:0] RST_LOCK_INDICATOR_DELAY_REG = 16'h03e8;
    localparam logic [15:0] RST_MODULATOR_RESET_WAIT_HIGH = 16'h0000;
    localparam logic [15:0] RST_MODULATOR_RESET_WAIT_LOW = 16'hc350;
    localparam logic [15:0] RST_FRAME_REF_CONTROL        = 16'h0081;
    localparam logic [15:0] RST_FRAME_REF_DIVIDER_REG    = 16'h0000;
    localparam logic [15:0] RST_FRAME_REF_DELAY_A        = 16'h003f;
    localparam logic [15:0] RST_FRAME_REF_DELAY_B        = 16'h0000;

    // =========================================================
    // Field positions
    localparam int POS_PIN_DISREGARD  = 15;
    localparam int POS_HYSTERESIS     = 14;
    localparam int POS_BIAS_LSB       = 12;
    localparam int POS_FORMAT_LSB     = 9;
    localparam int POS_LOCK_KIND      = 0;
    localparam int POS_PREDIV_LSB     = 5;
    localparam int POS_BURST_MODE     = 4;
    localparam int POS_FR_ENABLE      = 3;
    localparam int POS_RELAY_MODE     = 2;
    localparam int POS_WEIGHT_LO_LSB  = 0;
    localparam int POS_WEIGHT_HI_LSB  = 6;
    localparam int POS_BURST_CNT_LSB  = 12;

    // =========================================================
    // Codes
    localparam logic [1:0] BIAS_INVALID     = 2'h3;
    localparam logic [2:0] FORMAT_LAST_OK   = 3'h3;
    localparam logic [2:0] PREDIV_BY1       = 3'h1;
    localparam logic [2:0] PREDIV_BY2       = 3'h2;
    localparam logic [2:0] PREDIV_BY4       = 3'h4;
    localparam logic [11:0] DIV_HALF_OFFSET = 12'h002;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic       hysteresis;
        logic [1:0] bias_level;
        logic [2:0] pin_format;
    } pin_cfg_t;

    typedef struct packed {
        logic [5:0] weight_1;
        logic [5:0] weight_2;
        logic [5:0] weight_3;
        logic [5:0] weight_4;
    } delay_weights_t;

    typedef struct packed {
        logic bias_invalid;
        logic format_invalid;
        logic prediv_invalid;
        logic weights_invalid;
    } cfg_flags_t;

endpackage

// >>> logic/tick_delay.sv
`timescale 1ns/1ps
module tick_delay
    import sync_cfg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        arm_i,
    input  wire logic        clear_i,
    input  wire logic        tick_i,
    input  wire logic [31:0] count_i,
    output logic             expired_o,
    output logic             busy_o
);
    logic        active_r;
    logic [31:0] cnt_r;

    // =========================================================
    // Arm loads the wait; clear abandons it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            active_r <= 1'b0;
        end else if (arm_i) begin
            active_r <= 1'b1;
        end else if (clear_i) begin
            active_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 32'h0000_0000;
        end else if (arm_i) begin
            cnt_r <= count_i;
        end else if (active_r && tick_i && cnt_r != 32'h0000_0000) begin
            cnt_r <= cnt_r - 32'h0000_0001;
        end
    end

    assign expired_o = active_r && (cnt_r == 32'h0000_0000);
    assign busy_o    = active_r && (cnt_r != 32'h0000_0000);

endmodule // tick_delay

// >>> logic/sync_sysref_lock_config_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Pins used only when not disregarded, phase-align
// - Hysteresis bit enables high LVDS hysteresis
// - Bias code selects level; code 3 invalid
// - Format code selects standards; 4-7 invalid
// - Lock kind adds tuning-voltage check
// - Lock waits delay field phase-detector cycles
// - Zero delay asserts lock immediately
// - Modulator reset holds divider for wait count, in fractional phase-align mode only
// - Pre-divider 1, 2, 4; others invalid
// - Burst bit selects pulser in master mode
// - Relay bit chooses master or repeater
// - Divider ratio is twice code plus four
// - Pulser emits burst count pulses
module sync_sysref_lock_config_regs
    import sync_cfg_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic                       resetn_i,
    input  wire logic [6:0]                 addr_i,
    input  wire logic [15:0]                wdata_i,
    input  wire logic                       wr_i,
    input  wire logic                       rd_i,
    output logic [15:0]                     rdata_o,
    input  wire logic                       pfd_tick_i,
    input  wire logic                       phase_align_mode_i,
    input  wire logic                       fractional_mode_i,
    input  wire logic                       phase_align_pin_i,
    input  wire logic                       frame_ref_request_pin_i,
    input  wire logic                       vco_cal_ok_i,
    input  wire logic                       vtune_ok_i,
    input  wire logic                       modulator_reset_i,
    input  wire logic                       frame_ref_relay_in_i,
    output sync_cfg_pkg::pin_cfg_t          pin_cfg_o,
    output sync_cfg_pkg::delay_weights_t    delay_weights_o,
    output sync_cfg_pkg::cfg_flags_t        cfg_flags_o,
    output logic                            phase_align_sync_o,
    output logic                            lock_indicator_o,
    output logic                            vco_div_hold_o,
    output logic                            frame_ref_o
);
    import sync_cfg_pkg::*;

    // =========================================================
    // Helpers
    function automatic logic prediv_ok(input logic [2:0] code);
        return (code == PREDIV_BY1) || (code == PREDIV_BY2) || (code == PREDIV_BY4);
    endfunction

    function automatic logic wr_hit(input logic wr, input logic [6:0] a, input logic [6:0] ofs);
        return wr && (a == ofs);
    endfunction

    // =========================================================
    // Register storage
    logic [15:0] pin_cfg_r, lock_sel_r, lock_dly_r, wait_hi_r, wait_lo_r;
    logic [15:0] fr_ctrl_r, fr_div_r, fr_dly_a_r, fr_dly_b_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_cfg_r  <= RST_EXT_INPUT_PIN_CONFIG;
            lock_sel_r <= RST_LOCK_INDICATOR_SELECT;
            lock_dly_r <= RST_LOCK_INDICATOR_DELAY_REG;
            wait_hi_r  <= RST_MODULATOR_RESET_WAIT_HIGH;
            wait_lo_r  <= RST_MODULATOR_RESET_WAIT_LOW;
            fr_ctrl_r  <= RST_FRAME_REF_CONTROL;
            fr_div_r   <= RST_FRAME_REF_DIVIDER_REG;
            fr_dly_a_r <= RST_FRAME_REF_DELAY_A;
            fr_dly_b_r <= RST_FRAME_REF_DELAY_B;
        end else if (wr_i) begin
            case (addr_i)
                OFS_EXT_INPUT_PIN_CONFIG:      pin_cfg_r  <= wdata_i;
                OFS_LOCK_INDICATOR_SELECT:     lock_sel_r <= wdata_i;
                OFS_LOCK_INDICATOR_DELAY_REG:  lock_dly_r <= wdata_i;
                OFS_MODULATOR_RESET_WAIT_HIGH: wait_hi_r  <= wdata_i;
                OFS_MODULATOR_RESET_WAIT_LOW:  wait_lo_r  <= wdata_i;
                OFS_FRAME_REF_CONTROL:         fr_ctrl_r  <= wdata_i;
                OFS_FRAME_REF_DIVIDER_REG:     fr_div_r   <= wdata_i;
                OFS_FRAME_REF_DELAY_A:         fr_dly_a_r <= wdata_i;
                OFS_FRAME_REF_DELAY_B:         fr_dly_b_r <= wdata_i;
                default: ;
            endcase
        end
    end

    // =========================================================
    // Field decode
    logic        pin_disregard, lock_kind, burst_mode, fr_enable, relay_mode;
    logic [2:0]  prediv, burst_hi;
    logic [3:0]  burst_count;
    logic [10:0] divider;
    logic [31:0] mod_wait;
    logic [6:0]  weight_sum;
    cfg_flags_t  flags;

    assign pin_disregard = pin_cfg_r[POS_PIN_DISREGARD];
    assign lock_kind     = lock_sel_r[POS_LOCK_KIND];
    assign prediv        = fr_ctrl_r[POS_PREDIV_LSB +: 3];
    assign burst_mode    = fr_ctrl_r[POS_BURST_MODE];
    assign fr_enable     = fr_ctrl_r[POS_FR_ENABLE];
    assign relay_mode    = fr_ctrl_r[POS_RELAY_MODE];
    assign divider       = fr_div_r[10:0];
    assign burst_count   = fr_dly_b_r[POS_BURST_CNT_LSB +: 4];
    assign mod_wait      = {wait_hi_r, wait_lo_r};
    assign burst_hi      = 3'h0;
    assign weight_sum    = {1'b0, fr_dly_a_r[5:0]} + {1'b0, fr_dly_a_r[11:6]}
                         + {1'b0, fr_dly_b_r[5:0]} + {1'b0, fr_dly_b_r[11:6]};

    assign flags.bias_invalid    = (pin_cfg_r[POS_BIAS_LSB +: 2] == BIAS_INVALID);
    assign flags.format_invalid  = (pin_cfg_r[POS_FORMAT_LSB +: 3] > FORMAT_LAST_OK);
    assign flags.prediv_invalid  = !prediv_ok(prediv);
    // Only the sum is checked; the two-zero pattern is left to software
    assign flags.weights_invalid = (weight_sum != 7'h3f);

    // =========================================================
    // Configuration outputs to the analog pin receivers and delay line
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_cfg_o       <= '0;
            delay_weights_o <= '0;
            cfg_flags_o     <= '0;
        end else begin
            pin_cfg_o.hysteresis <= pin_cfg_r[POS_HYSTERESIS];
            pin_cfg_o.bias_level <= pin_cfg_r[POS_BIAS_LSB +: 2];
            pin_cfg_o.pin_format <= pin_cfg_r[POS_FORMAT_LSB +: 3];
            delay_weights_o      <= {fr_dly_a_r[5:0], fr_dly_a_r[11:6], fr_dly_b_r[5:0], fr_dly_b_r[11:6]};
            cfg_flags_o          <= flags;
        end
    end

    // =========================================================
    // External pins: honoured only in phase-align mode and when not disregarded
    logic pins_used, req_q_r, req_edge;

    assign pins_used = !pin_disregard && phase_align_mode_i;
    assign req_edge  = pins_used && frame_ref_request_pin_i && !req_q_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_q_r            <= 1'b0;
            phase_align_sync_o <= 1'b0;
        end else begin
            req_q_r            <= frame_ref_request_pin_i;
            phase_align_sync_o <= pins_used && phase_align_pin_i;
        end
    end

    // =========================================================
    // Lock indicator and modulator wait, both counted in phase-detector cycles
    logic lock_src, lock_src_q_r, mod_arm, lock_exp, hold_busy;

    assign lock_src = vco_cal_ok_i && (!lock_kind || vtune_ok_i);
    assign mod_arm  = modulator_reset_i && phase_align_mode_i && fractional_mode_i;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_src_q_r <= 1'b0;
        end else begin
            lock_src_q_r <= lock_src;
        end
    end

    tick_delay u_lock_delay (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .arm_i     (lock_src && !lock_src_q_r),
        .clear_i   (!lock_src),
        .tick_i    (pfd_tick_i),
        .count_i   ({16'h0000, lock_dly_r}),
        .expired_o (lock_exp),
        .busy_o    ()
    );

    tick_delay u_mod_wait (
        .clk_i     (clk_i),
        .resetn_i  (resetn_i),
        .arm_i     (mod_arm),
        .clear_i   (1'b0),
        .tick_i    (pfd_tick_i),
        .count_i   (mod_wait),
        .expired_o (),
        .busy_o    (hold_busy)
    );

    // Lock is dropped at once when its source falls, without waiting
    assign lock_indicator_o = lock_exp && lock_src;
    assign vco_div_hold_o   = hold_busy;

    // =========================================================
    // Frame-reference generator
    logic        master_run, pre_tick, phase_r, phase_nxt;
    logic [2:0]  pre_cnt_r;
    logic [11:0] half_cnt_r, half_len;
    logic [3:0]  burst_left_r;

    assign half_len   = {1'b0, divider} + DIV_HALF_OFFSET;
    assign master_run = fr_enable && !relay_mode && prediv_ok(prediv)
                      && (!burst_mode || burst_left_r != 4'h0);
    assign pre_tick   = master_run && pfd_tick_i && (pre_cnt_r == 3'h0);
    assign phase_nxt  = master_run && (pre_tick && half_cnt_r == 12'h000 ? !phase_r : phase_r);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pre_cnt_r <= 3'h0;
        end else if (!master_run) begin
            pre_cnt_r <= 3'h0;
        end else if (pfd_tick_i) begin
            pre_cnt_r <= (pre_cnt_r == 3'h0) ? prediv - 3'h1 : pre_cnt_r - 3'h1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            half_cnt_r <= 12'h000;
            phase_r    <= 1'b0;
        end else if (!master_run) begin
            half_cnt_r <= 12'h000;
            phase_r    <= 1'b0;
        end else if (pre_tick) begin
            half_cnt_r <= (half_cnt_r == 12'h000) ? half_len - 12'h001 : half_cnt_r - 12'h001;
            phase_r    <= phase_nxt;
        end
    end

    // A burst starts on a request edge or on a write of the burst count;
    // a new start while pulsing restarts the count rather than queueing
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            burst_left_r <= 4'h0;
        end else if (req_edge || wr_hit(wr_i, addr_i, OFS_FRAME_REF_DELAY_B)) begin
            burst_left_r <= req_edge ? burst_count : wdata_i[POS_BURST_CNT_LSB +: 4];
        end else if (burst_mode && phase_r && !phase_nxt && burst_left_r != 4'h0) begin
            burst_left_r <= burst_left_r - 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frame_ref_o <= 1'b0;
        end else begin
            frame_ref_o <= fr_enable && (relay_mode ? frame_ref_relay_in_i : phase_r);
        end
    end

    // =========================================================
    // Read port: data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                OFS_EXT_INPUT_PIN_CONFIG:      rdata_o <= pin_cfg_r;
                OFS_LOCK_INDICATOR_SELECT:     rdata_o <= lock_sel_r;
                OFS_LOCK_INDICATOR_DELAY_REG:  rdata_o <= lock_dly_r;
                OFS_MODULATOR_RESET_WAIT_HIGH: rdata_o <= wait_hi_r;
                OFS_MODULATOR_RESET_WAIT_LOW:  rdata_o <= wait_lo_r;
                OFS_FRAME_REF_CONTROL:         rdata_o <= fr_ctrl_r;
                OFS_FRAME_REF_DIVIDER_REG:     rdata_o <= fr_div_r;
                OFS_FRAME_REF_DELAY_A:         rdata_o <= fr_dly_a_r;
                OFS_FRAME_REF_DELAY_B:         rdata_o <= fr_dly_b_r;
                OFS_BLOCK_STATUS:              rdata_o <= {burst_left_r, burst_hi, lock_indicator_o,
                                                           vco_div_hold_o, phase_r, pins_used, 1'b0, flags};
                default:                       rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    logic [16:0] src_ticks_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            src_ticks_r <= 17'h00000;
        end else if (!lock_src || !lock_src_q_r) begin
            src_ticks_r <= 17'h00000;
        end else if (pfd_tick_i && src_ticks_r != 17'h1ffff) begin
            src_ticks_r <= src_ticks_r + 17'h00001;
        end
    end

    a_pin_ignore_gate: assert property (!pins_used |=> !phase_align_sync_o)
        else $error("sync output passed while pins disregarded");
    a_hyst_follows: assert property (wr_hit(wr_i, addr_i, OFS_EXT_INPUT_PIN_CONFIG)
        |=> ##1 pin_cfg_o.hysteresis == $past(wdata_i[POS_HYSTERESIS], 2))
        else $error("hysteresis output not taken from write");
    a_bias_invalid: assert property (pin_cfg_o.bias_level == BIAS_INVALID |-> cfg_flags_o.bias_invalid)
        else $error("bias code 3 not flagged");
    a_format_invalid: assert property (pin_cfg_o.pin_format[2] |-> cfg_flags_o.format_invalid)
        else $error("format code above 3 not flagged");
    a_lock_kind_vtune: assert property (lock_indicator_o && lock_kind |-> vtune_ok_i && vco_cal_ok_i)
        else $error("lock without tuning-voltage check");
    a_lock_delay_len: assert property ($rose(lock_indicator_o) && $stable(lock_dly_r) && lock_dly_r != 16'h0000
        |-> src_ticks_r == {1'b0, lock_dly_r})
        else $error("lock delay length wrong");
    a_lock_zero_delay: assert property ($rose(lock_src) && lock_dly_r == 16'h0000 |=> lock_indicator_o || !lock_src)
        else $error("zero delay lock not immediate");
    a_mod_hold_start: assert property (mod_arm && mod_wait != 32'h0000_0000 |=> vco_div_hold_o)
        else $error("divider not held after modulator reset");
    a_prediv_stop: assert property (flags.prediv_invalid && !relay_mode |=> ##1 !frame_ref_o)
        else $error("generator ran with invalid pre-divider");
    a_burst_end_quiet: assert property (burst_mode && !relay_mode && burst_left_r == 4'h0 |=> !phase_r)
        else $error("pulser ran past end of burst");
    a_relay_pass: assert property (fr_enable && relay_mode |=> frame_ref_o == $past(frame_ref_relay_in_i))
        else $error("repeater did not pass input");
    a_div_half_bound: assert property (master_run |-> half_cnt_r <= {1'b0, divider} + 12'h001)
        else $error("half-period counter out of range");
    a_burst_count_dec: assert property (burst_mode && $fell(phase_r) && !$past(req_edge)
        && !$past(wr_hit(wr_i, addr_i, OFS_FRAME_REF_DELAY_B)) |-> burst_left_r == $past(burst_left_r) - 4'h1)
        else $error("burst count not decremented per pulse");

    c_lock_after_delay: cover property ($rose(lock_indicator_o) && lock_dly_r != 16'h0000);
    c_burst_done:       cover property (burst_mode && $fell(burst_left_r != 4'h0));
    c_hold_released:    cover property ($fell(vco_div_hold_o));
    c_relay_pulse:      cover property (relay_mode && $rose(frame_ref_o));

endmodule // sync_sysref_lock_config_regs

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sync_cfg_pkg::*;
    logic clk_i, resetn_i, wr_i, rd_i, pfd_tick_i, phase_align_mode_i, fractional_mode_i;
    logic phase_align_pin_i, frame_ref_request_pin_i, vco_cal_ok_i, vtune_ok_i, modulator_reset_i;
    logic frame_ref_relay_in_i, phase_align_sync_o, lock_indicator_o, vco_div_hold_o, frame_ref_o;
    logic [6:0]     addr_i;
    logic [15:0]    wdata_i, rdata_o, d;
    pin_cfg_t       pin_cfg_o;
    delay_weights_t delay_weights_o;
    cfg_flags_t     cfg_flags_o;
    int err_total = 0, num_checks = 0, cyc = 0, seed, n, w, k, i;
    logic [6:0]  ofs[9] = '{7'h3a, 7'h3b, 7'h3c, 7'h45, 7'h46, 7'h47, 7'h48, 7'h49, 7'h4a};
    logic [15:0] rv[9]  = '{16'h8001, 16'h0001, 16'h03e8, 16'h0000, 16'hc350, 16'h0081, 16'h0000, 16'h003f, 16'h0000};
    int          pre[3] = '{1, 2, 4};

    sync_sysref_lock_config_regs DUT (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .pfd_tick_i, .phase_align_mode_i, .fractional_mode_i, .phase_align_pin_i, .frame_ref_request_pin_i,
        .vco_cal_ok_i, .vtune_ok_i, .modulator_reset_i, .frame_ref_relay_in_i, .pin_cfg_o, .delay_weights_o,
        .cfg_flags_o, .phase_align_sync_o, .lock_indicator_o, .vco_div_hold_o, .frame_ref_o);

    // ==========================================================
    // Clock and hang guard
    initial clk_i = 1'b0;
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end

    // ==========================================================
    // Helpers
    task automatic final_report();
        if (err_total == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    function automatic logic sig(input int s);
        return (s == 0) ? lock_indicator_o : (s == 1) ? vco_div_hold_o : frame_ref_o;
    endfunction
    // Cycles until the selected output reaches lvl, capped so a stuck output cannot hang
    task automatic span(input int s, input logic lvl, output int c);
        c = 0;
        while (sig(s) !== lvl && c < 300) begin
            @(posedge clk_i);
            #1 c++;
        end
    endtask
    function automatic logic [5:0] pin_exp(input logic [15:0] v);
        return {v[14], v[13:12], v[11:9]};
    endfunction

    // ==========================================================
    // Main sequence
    initial begin
        {resetn_i, wr_i, rd_i, phase_align_mode_i, fractional_mode_i, phase_align_pin_i} = '0;
        {frame_ref_request_pin_i, vco_cal_ok_i, vtune_ok_i, modulator_reset_i, frame_ref_relay_in_i} = '0;
        {addr_i, wdata_i} = '0;
        pfd_tick_i = 1'b1;
        seed = 44;
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (i = 0; i < 9; i++) begin
            rd(ofs[i], d);
            chk(d, rv[i]);
        end
        chk(cfg_flags_o, 4'h0);
        chk(delay_weights_o[23:8], 16'hfc00);
        rd(7'h10, d);
        chk(d, 16'h0000);
        // Configuration outputs are registered one cycle behind the register
        for (i = 0; i < 24; i++) begin
            d = $random(seed);
            wr(7'h3a, d);
            @(posedge clk_i);
            #1 chk(pin_cfg_o, pin_exp(d));
            chk(cfg_flags_o.bias_invalid, d[13:12] == 2'h3);
            chk(cfg_flags_o.format_invalid, d[11:9] > 3'h3);
            rd(ofs[i % 9], d);
        end
        // Delay weights: random pattern, burst count kept at zero
        d = $random(seed);
        w = $random(seed);
        wr(7'h49, d);
        wr(7'h4a, w[15:0] & 16'h0fff);
        @(posedge clk_i);
        #1 chk(delay_weights_o[23:12], {d[5:0], d[11:6]});
        chk(delay_weights_o[11:0], {w[5:0], w[11:6]});
        chk(cfg_flags_o.weights_invalid, (d[5:0] + d[11:6] + w[5:0] + w[11:6]) != 63);
        // Pins follow only when not disregarded
        phase_align_mode_i <= 1'b1;
        phase_align_pin_i  <= 1'b1;
        wr(7'h3a, 16'h0001);
        repeat (3) @(posedge clk_i);
        #1 chk(phase_align_sync_o, 1'b1);
        wr(7'h3a, 16'h8001);
        repeat (3) @(posedge clk_i);
        #1 chk(phase_align_sync_o, 1'b0);
        // Lock delay with calibration-only source, then zero delay, then with the tuning-voltage check added
        wr(7'h3b, 16'h0000);
        k = 3 + ($unsigned($random(seed)) % 8);
        wr(7'h3c, k[15:0]);
        vco_cal_ok_i <= 1'b1;
        span(0, 1'b1, n);
        chk(n >= k && n <= k + 2, 1'b1);
        vco_cal_ok_i <= 1'b0;
        @(posedge clk_i);
        #1 chk(lock_indicator_o, 1'b0);
        wr(7'h3c, 16'h0000);
        vco_cal_ok_i <= 1'b1;
        @(posedge clk_i);
        #1 chk(lock_indicator_o, 1'b1);
        vco_cal_ok_i <= 1'b0;
        wr(7'h3b, 16'h0001);
        vco_cal_ok_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        #1 chk(lock_indicator_o, 1'b0);
        vtune_ok_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 chk(lock_indicator_o, 1'b1);
        // Modulator reset wait, then a zero wait, then a non-fractional pulse with a real wait
        k = 4 + ($unsigned($random(seed)) % 9);
        wr(7'h45, 16'h0000);
        wr(7'h46, k[15:0]);
        for (i = 0; i < 3; i++) begin
            fractional_mode_i <= (i != 2);
            if (i != 0) wr(7'h46, (i == 1) ? 16'h0000 : k[15:0]);
            @(posedge clk_i);
            modulator_reset_i <= 1'b1;
            @(posedge clk_i);
            modulator_reset_i <= 1'b0;
            #1 chk(vco_div_hold_o, i == 0);
            span(1, 1'b0, n);
            if (i == 0) chk(n >= k - 2 && n <= k, 1'b1);
        end
        // Continuous generator: high half is prediv*(divider+2) ticks for every valid prediv
        // Stopped before each change so no half period mixes two settings
        for (i = 0; i < 3; i++) begin
            wr(7'h47, 16'h0001);
            wr(7'h48, i[15:0]);
            wr(7'h47, 16'(16'h0009 | (pre[i] << 5)));
            span(2, 1'b1, n);
            span(2, 1'b0, w);
            chk(w, pre[i] * (i + 2));
        end
        wr(7'h47, 16'h0069);
        repeat (30) @(posedge clk_i);
        #1 chk(frame_ref_o, 1'b0);
        chk(cfg_flags_o.prediv_invalid, 1'b1);
        // Burst: first started by a count write, then by a request pin edge
        wr(7'h48, 16'h0001);
        wr(7'h47, 16'h0039);
        wr(7'h3a, 16'h0001);
        k = 1 + ($unsigned($random(seed)) % 4);
        for (i = 0; i < 2; i++) begin
            if (i == 0) wr(7'h4a, k[15:0] << 12);
            else frame_ref_request_pin_i <= 1'b1;
            n = 0;
            w = 0;
            repeat (120) begin
                @(posedge clk_i);
                #1 if (frame_ref_o === 1'b1 && w == 0) n++;
                w = frame_ref_o;
            end
            chk(n, k);
        end
        // Repeater follows its input one cycle later
        wr(7'h47, 16'h002d);
        frame_ref_relay_in_i <= 1'b1;
        @(posedge clk_i);
        @(posedge clk_i);
        #1 chk(frame_ref_o, 1'b1);
        frame_ref_relay_in_i <= 1'b0;
        @(posedge clk_i);
        @(posedge clk_i);
        #1 chk(frame_ref_o, 1'b0);
        final_report();
    end
endmodule // tb_top
